// ==== hdl/cci_pkg.sv ====
// Purpose: Shared constants and types for the caption line inserter.
// Assumes: Clock of 40 MHz; line and field position come from a timing generator.
// Notes: Field select codes: 0 off, 1 odd only, 2 even only, 3 both.
package cci_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int BIT_RATE_HZ = 503497;
    // Cycles per caption bit, rounded down so the bit is never stretched.
    localparam int BIT_CYC = CLK_HZ / BIT_RATE_HZ;
    localparam int RUNIN_CYCLES = 7;
    localparam int GAP_BITS = 2;
    localparam int DATA_BITS = 16;
    localparam int ODD_LINE = 21;
    localparam int EVEN_LINE = 284;
    localparam int EVEN_IGNORE_LINE = 282;
    localparam int START_OFFSET_CYC = 400;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [7:0] LEVEL_BLANK = 8'h10;
    localparam logic [7:0] LEVEL_ONE = 8'h50;

    typedef enum logic [2:0] {
        CCI_IDLE,
        CCI_WAIT,
        CCI_RUNIN,
        CCI_GAP,
        CCI_START,
        CCI_DATA
    } cci_state_t;
endpackage

// ==== hdl/cci_link_if.sv ====
// Purpose: Carries bit timing between the inserter and its bit timer.
// Assumes: One clock domain.
// Notes: Tick is a one-cycle pulse at bit rate and a phase for the run-in.
`timescale 1ns/100ps
interface cci_link_if;
    logic run;
    logic tick;
    logic half;
    modport timer (input run, output tick, output half);
    modport user (output run, input tick, input half);
endinterface

// ==== hdl/cci_bit_timer.sv ====
// Purpose: Bit-rate divider for the caption waveform.
// Assumes: run is held for a whole caption line.
// Notes: Restarts phase whenever run falls so every line is locked alike.
`timescale 1ns/100ps
module cci_bit_timer #(
    parameter int BIT_CYC = cci_pkg::BIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    cci_link_if.timer lnk
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
        logic half;
    } cci_tmr_t;
    cci_tmr_t st, next_st;

    // Refuse bit periods that the 16-bit counter or the half phase cannot serve.
    if (BIT_CYC < 4 || BIT_CYC > 65535)
    begin : g_bad_bit_cyc
        $error("BIT_CYC out of range");
    end

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!lnk.run)
        begin
            next_st.cnt = 16'h0000;
            next_st.half = 1'b0;
        end
        else if (st.cnt == 16'(BIT_CYC - 1))
        begin
            next_st.cnt = 16'h0000;
            next_st.tick = 1'b1;
            next_st.half = 1'b0;
        end
        else
        begin
            next_st.cnt = st.cnt + 16'h0001;
            if (st.cnt == 16'(BIT_CYC / 2 - 1))
            begin
                next_st.half = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign lnk.tick = st.tick;
    assign lnk.half = st.half;

    tick_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE2]
        st.tick |=> !st.tick [*3]) else $error("bit tick too close");
endmodule

// ==== hdl/cci_inserter.sv ====
// Purpose: Builds the caption waveform on the caption lines of each field.
// Assumes: i_line and i_odd_field come from the encoder timing generator.
// Notes: Output is a level code per cycle; run-in is a square approximation.
`timescale 1ns/100ps
// How it works
// [RULE1] Odd field line 21 carries caption bytes.
// [RULE2] Run-in is seven cycles locked to bits.
// [RULE3] Two blank bit periods, then start one.
// [RULE4] Sixteen data bits from two caption bytes.
// [RULE5] Even field line 284 sends extended bytes.
// [RULE6] All caption timing generated inside here.
// [RULE7] Pixels ignored on lines 21 and 282.
// [RULE8] Internal bit timer divides i_clk down to bit rate; no outside clock.
// [RULE9] Field select: odd, even or both fields.
// [RULE10] Low byte first, each byte LSB first.
module cci_inserter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_line_start,
    input wire logic [9:0] i_line,
    input wire logic i_odd_field,
    input wire logic [1:0] i_caption_field_select,
    input wire logic [7:0] i_cap_byte0,
    input wire logic [7:0] i_cap_byte1,
    input wire logic [7:0] i_ext_byte0,
    input wire logic [7:0] i_ext_byte1,
    input wire logic [7:0] i_pixel,
    output logic [7:0] o_video,
    output logic o_caption_active,
    output logic o_pixel_ignored
);
    typedef struct packed {
        cci_pkg::cci_state_t state;
        logic [15:0] wait_cnt;
        logic [4:0] bit_cnt;
        logic [15:0] shreg;
        logic [7:0] video;
        logic active;
        logic ignore;
    } cci_main_t;
    cci_main_t st, next_st;

    cci_link_if lnk ();

    cci_bit_timer #(.BIT_CYC(cci_pkg::BIT_CYC)) u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .lnk(lnk)
    );

    logic odd_hit;
    logic even_hit;
    logic ign_line;

    always_comb
    begin
        odd_hit = i_odd_field && i_line == 10'(cci_pkg::ODD_LINE)
            && i_caption_field_select[0]; // see [RULE1] see [RULE9]
        even_hit = !i_odd_field && i_line == 10'(cci_pkg::EVEN_LINE)
            && i_caption_field_select[1]; // see [RULE5] see [RULE9]
        ign_line = (i_odd_field && i_line == 10'(cci_pkg::ODD_LINE))
            || (!i_odd_field && i_line == 10'(cci_pkg::EVEN_IGNORE_LINE)); // see [RULE7]
    end

    assign lnk.run = st.state != cci_pkg::CCI_IDLE && st.state != cci_pkg::CCI_WAIT;

    always_comb
    begin
        next_st = st;
        next_st.ignore = ign_line;
        // Pixel data passes except on the ignored lines 21 (odd field) and 282 (even field) and while the caption waveform is sent.
        next_st.video = ign_line ? cci_pkg::LEVEL_BLANK : i_pixel; // see [RULE7]
        unique case (st.state)
            cci_pkg::CCI_IDLE:
            begin
                next_st.active = 1'b0;
                if (i_line_start && (odd_hit || even_hit))
                begin
                    // Low byte in low bits so it leaves first.
                    next_st.shreg = odd_hit ? {i_cap_byte1, i_cap_byte0}
                        : {i_ext_byte1, i_ext_byte0}; // see [RULE4] see [RULE5] see [RULE10]
                    next_st.wait_cnt = 16'h0000;
                    next_st.state = cci_pkg::CCI_WAIT; // see [RULE6]
                end
            end
            cci_pkg::CCI_WAIT:
            begin
                next_st.wait_cnt = st.wait_cnt + 16'h0001;
                if (st.wait_cnt == 16'(cci_pkg::START_OFFSET_CYC - 1))
                begin
                    next_st.bit_cnt = 5'h00;
                    next_st.active = 1'b1;
                    next_st.state = cci_pkg::CCI_RUNIN;
                end
            end
            cci_pkg::CCI_RUNIN:
            begin
                // Run-in is one square cycle per bit period, so bit-locked.
                next_st.video = lnk.half ? cci_pkg::LEVEL_BLANK : cci_pkg::LEVEL_ONE; // see [RULE2]
                if (lnk.tick)
                begin
                    next_st.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.bit_cnt == 5'(cci_pkg::RUNIN_CYCLES - 1))
                    begin
                        next_st.bit_cnt = 5'h00;
                        next_st.state = cci_pkg::CCI_GAP;
                    end
                end
            end
            cci_pkg::CCI_GAP:
            begin
                next_st.video = cci_pkg::LEVEL_BLANK; // see [RULE3]
                if (lnk.tick)
                begin
                    next_st.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.bit_cnt == 5'(cci_pkg::GAP_BITS - 1))
                    begin
                        next_st.state = cci_pkg::CCI_START;
                    end
                end
            end
            cci_pkg::CCI_START:
            begin
                next_st.video = cci_pkg::LEVEL_ONE; // see [RULE3]
                if (lnk.tick)
                begin
                    next_st.bit_cnt = 5'h00;
                    next_st.state = cci_pkg::CCI_DATA;
                end
            end
            cci_pkg::CCI_DATA:
            begin
                next_st.video = st.shreg[0] ? cci_pkg::LEVEL_ONE
                    : cci_pkg::LEVEL_BLANK; // see [RULE4] see [RULE10]
                if (lnk.tick)
                begin
                    next_st.shreg = {1'b0, st.shreg[15:1]};
                    next_st.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.bit_cnt == 5'(cci_pkg::DATA_BITS - 1))
                    begin
                        next_st.active = 1'b0;
                        next_st.state = cci_pkg::CCI_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_video = st.video;
    assign o_caption_active = st.active;
    assign o_pixel_ignored = st.ignore;

    // Checker-only count of cycles spent waiting, kept apart from the state counter.
    logic [15:0] wait_seen;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_seen <= 16'h0000;
        end
        else if (st.state == cci_pkg::CCI_WAIT)
        begin
            wait_seen <= wait_seen + 16'h0001;
        end
        else
        begin
            wait_seen <= 16'h0000;
        end
    end

    sequence s_runin_end;
        st.state == cci_pkg::CCI_RUNIN && lnk.tick && st.bit_cnt == 5'h06;
    endsequence

    sequence s_wait_done;
        st.state == cci_pkg::CCI_WAIT && wait_seen == 16'(cci_pkg::START_OFFSET_CYC - 1);
    endsequence

    runin_to_gap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE2]
        s_runin_end |=> st.state == cci_pkg::CCI_GAP) else $error("run-in length wrong");
    gap_blank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE3]
        st.state == cci_pkg::CCI_GAP |=> o_video == cci_pkg::LEVEL_BLANK)
        else $error("gap not blank");
    start_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE3]
        st.state == cci_pkg::CCI_START |=> o_video == cci_pkg::LEVEL_ONE)
        else $error("start bit not one");
    data_lsb_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE10]
        st.state == cci_pkg::CCI_DATA |=> o_video == ($past(st.shreg[0]) ?
        cci_pkg::LEVEL_ONE : cci_pkg::LEVEL_BLANK)) else $error("data bit wrong");
    odd_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE1]
        st.state == cci_pkg::CCI_IDLE && i_line_start && odd_hit
        |=> st.shreg == {$past(i_cap_byte1), $past(i_cap_byte0)}) else $error("odd bytes");
    even_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE5]
        st.state == cci_pkg::CCI_IDLE && i_line_start && even_hit
        |=> st.shreg == {$past(i_ext_byte1), $past(i_ext_byte0)}) else $error("ext bytes");
    sel_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE9]
        st.state == cci_pkg::CCI_IDLE && i_caption_field_select == 2'h0
        |=> st.state == cci_pkg::CCI_IDLE) else $error("select ignored");
    pix_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE7]
        ign_line && !lnk.run |=> o_pixel_ignored && o_video == cci_pkg::LEVEL_BLANK)
        else $error("pixel passed");
    data_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE4]
        st.state == cci_pkg::CCI_DATA && lnk.tick && st.bit_cnt == 5'h0F
        |=> st.state == cci_pkg::CCI_IDLE && !o_caption_active) else $error("data length");
    wait_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE6]
        s_wait_done |=> st.state == cci_pkg::CCI_RUNIN) else $error("offset wrong");
    wait_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [RULE6]
        st.state == cci_pkg::CCI_WAIT && wait_seen < 16'(cci_pkg::START_OFFSET_CYC - 1)
        |=> st.state == cci_pkg::CCI_WAIT) else $error("left wait early");
endmodule

// ==== tb/cci_rx_model.sv ====
// Purpose: Receiver model that decodes one caption line from the video output.
// Assumes: Each bit lasts BIT_CYC cycles, counted from the rise of the active flag.
// Notes: Levels are sampled at fixed phases, so a small drift still decodes.
`timescale 1ns/100ps
module cci_rx_model #(
    parameter int BIT_CYC = cci_pkg::BIT_CYC
) (
    input wire logic i_clk,
    input wire logic [7:0] i_video,
    input wire logic i_active,
    output logic [15:0] o_word,
    output logic o_fmt_ok,
    output int o_lines
);
    int t = 0;
    int b;
    int ph;
    logic [15:0] w = 16'h0000;
    logic ok = 1'b0;
    logic was = 1'b0;
    int nlines = 0;
    assign o_lines = nlines;
    always @(posedge i_clk)
    begin
        #2;
        if (i_active === 1'b1)
        begin
            if (was !== 1'b1)
            begin
                t = 0;
                ok = 1'b1;
            end
            b = t / BIT_CYC;
            ph = t % BIT_CYC;
            if (b < 7 && ph == BIT_CYC / 4)
                ok &= (i_video === cci_pkg::LEVEL_ONE);
            if (b < 7 && ph == 3 * BIT_CYC / 4)
                ok &= (i_video === cci_pkg::LEVEL_BLANK);
            if ((b == 7 || b == 8) && ph == BIT_CYC / 2)
                ok &= (i_video === cci_pkg::LEVEL_BLANK);
            if (b == 9 && ph == BIT_CYC / 2)
                ok &= (i_video === cci_pkg::LEVEL_ONE);
            if (b >= 10 && b < 26 && ph == BIT_CYC / 2)
                w[b - 10] = (i_video === cci_pkg::LEVEL_ONE);
            t++;
        end
        else if (was === 1'b1)
        begin
            o_word = w;
            o_fmt_ok = ok && t >= 26 * BIT_CYC && t < 27 * BIT_CYC;
            nlines++;
        end
        was = i_active;
    end
endmodule

// ==== tb/closed_caption_line_inserter_tb_top.sv ====
// Purpose: Self-checking bench for the caption line inserter.
// Assumes: Inputs change one small delay after each rising clock edge.
// Notes: Field select is swept over both fields; pixel blanking is checked by table.
`timescale 1ns/100ps
module closed_caption_line_inserter_tb_top;
    localparam time DLY = 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic line_start = 1'b0;
    logic [9:0] line = 10'h000;
    logic odd_f = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [7:0] cap0 = 8'h00;
    logic [7:0] cap1 = 8'h00;
    logic [7:0] ext0 = 8'h00;
    logic [7:0] ext1 = 8'h00;
    logic [7:0] pixel = 8'hA5;
    logic [7:0] video;
    logic active;
    logic ignored;
    logic [15:0] word;
    logic fmt_ok;
    int lines;
    int errors = 0;
    int checked = 0;
    cci_inserter i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_line_start(line_start),
        .i_line(line), .i_odd_field(odd_f), .i_caption_field_select(sel),
        .i_cap_byte0(cap0), .i_cap_byte1(cap1), .i_ext_byte0(ext0), .i_ext_byte1(ext1),
        .i_pixel(pixel), .o_video(video), .o_caption_active(active),
        .o_pixel_ignored(ignored));
    cci_rx_model i_rx (.i_clk(clk), .i_video(video), .i_active(active),
        .o_word(word), .o_fmt_ok(fmt_ok), .o_lines(lines));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Starts one line and, when a caption is due, judges latency and decoded bits.
    task automatic cap_line(input logic [9:0] ln, input logic odd, input logic on,
        input logic [15:0] exp);
        int n;
        int k;
        k = lines;
        @(posedge clk);
        #DLY;
        odd_f = odd;
        line = ln;
        // Line start marks the caption line; the bit clock is divided from i_clk inside the inserter.
        line_start = 1'b1;
        @(posedge clk);
        #DLY;
        line_start = 1'b0;
        n = 0;
        while (active !== 1'b1 && n < 600)
        begin
            @(posedge clk);
            #DLY;
            n++;
        end
        if (on === 1'b0)
        begin
            check(n, 600);
            return;
        end
        check(n, cci_pkg::START_OFFSET_CYC);
        n = 0;
        while (lines == k && n < 3000)
        begin
            @(posedge clk);
            #DLY;
            n++;
        end
        if (n == 3000)
        begin
            errors++;
            report_and_stop();
        end
        check(word, exp);
        check(fmt_ok, 1);
    endtask
    // Holds each line for a few cycles and compares output against pixel or blank.
    task automatic pixel_table();
        logic [10:0] tbl [4] = '{{1'b1, 10'd20}, {1'b1, 10'd21}, {1'b0, 10'd282},
            {1'b0, 10'd284}};
        logic hit;
        for (int i = 0; i < 4; i++)
        begin
            odd_f = tbl[i][10];
            line = tbl[i][9:0];
            hit = (i == 1 || i == 2);
            repeat (3) @(posedge clk);
            #DLY;
            check(ignored, hit);
            check(video, hit ? cci_pkg::LEVEL_BLANK : 8'hA5);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #DLY;
        rst_n = 1'b1;
        sel = 2'h3;
        pixel_table();
        for (int i = 0; i < 8; i++)
        begin
            sel = i[2:1];
            cap0 = 8'h80 | 8'(i);
            cap1 = 8'h01 << i;
            ext0 = 8'h5A ^ 8'(i);
            ext1 = 8'hC3;
            if (i[0])
                cap_line(10'd21, 1'b1, sel[0], {cap1, cap0});
            else
                cap_line(10'd284, 1'b0, sel[1], {ext1, ext0});
        end
        cap_line(10'd21, 1'b0, 1'b0, 16'h0000);
        report_and_stop();
    end
endmodule
